// ==== logic/module_sideband.v ====
`timescale 1ns/1ps
`include "sideband_defines.vh"
module module_sideband (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Host control pins
  input wire module_select_n,
  input wire module_reset_n,
  input wire low_power_request,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output wire sda_oe_n,
  output reg interrupt_n_out,
  output reg interrupt_n_oe_n,
  output reg module_present_n,
  // Optical path status
  input wire [3:0] tx_signal_loss_flag,
  input wire [3:0] rx_signal_loss_flag,
  input wire [3:0] tx_lock_loss_flag,
  input wire [3:0] rx_lock_loss_flag,
  input wire [3:0] tx_fault,
  // Diagnostic monitors
  input wire [15:0] temp_monitor,
  input wire [15:0] vcc_monitor,
  input wire [63:0] rx_power_monitor,
  input wire [63:0] tx_bias_monitor,
  input wire [63:0] tx_power_monitor,
  // Lane controls
  output reg high_power_enable,
  output wire [15:0] tx_equalization,
  output wire [15:0] rx_output_amplitude,
  output wire [15:0] rx_output_emphasis
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [4:0] pin_raw;
  reg [4:0] pin_meta_reg;
  reg [4:0] pin_sync_reg;
  wire scl_s;
  wire sda_s;
  wire select_s;
  wire reset_pin_s;
  wire low_power_s;

  assign pin_raw = {low_power_request, module_reset_n, module_select_n, sda_in, scl};

  genvar gp;
  generate
    for (gp = 0; gp < 5; gp = gp + 1) begin : g_sync
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          pin_meta_reg[gp] <= 1'b1;
          pin_sync_reg[gp] <= 1'b1;
        end else begin
          pin_meta_reg[gp] <= pin_raw[gp];
          pin_sync_reg[gp] <= pin_meta_reg[gp];
        end
      end
    end
  endgenerate

  assign scl_s = pin_sync_reg[0];
  assign sda_s = pin_sync_reg[1];
  assign select_s = !pin_sync_reg[2];
  assign reset_pin_s = pin_sync_reg[3];
  assign low_power_s = pin_sync_reg[4];

  // ----------------------------------------
  // Serial bus target
  // ----------------------------------------
  wire [7:0] reg_addr;
  wire wr_strobe;
  wire [7:0] wr_data;
  wire rd_strobe;
  reg [7:0] rd_data;

  twi_target u_twi (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .scl_level(scl_s),
    .sda_level(sda_s),
    .enable(select_s),
    .sda_oe_n(sda_oe_n),
    .reg_addr(reg_addr),
    .wr_strobe(wr_strobe),
    .wr_data(wr_data),
    .rd_strobe(rd_strobe),
    .rd_data(rd_data)
  );

  // ----------------------------------------
  // Reset pin filter and initialisation
  // ----------------------------------------
  reg [11:0] reset_cnt_reg;
  reg reset_hold_reg;
  reg [11:0] init_cnt_reg;
  reg not_ready_reg;
  reg reset_done_reg;
  wire status_read;

  assign status_read = rd_strobe && (reg_addr == `OFS_STATUS);

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_cnt_reg <= 12'h000;
      reset_hold_reg <= 1'b0;
      init_cnt_reg <= 12'h000;
      not_ready_reg <= 1'b1;
      reset_done_reg <= 1'b0;
    end else begin
      if (reset_pin_s) begin
        reset_cnt_reg <= 12'h000;
        reset_hold_reg <= 1'b0;
      end else if (reset_cnt_reg < `RESET_MIN_CYC) begin
        reset_cnt_reg <= reset_cnt_reg + 12'h001;
      end else begin
        reset_hold_reg <= 1'b1;
      end
      if (reset_hold_reg) begin
        init_cnt_reg <= 12'h000;
        not_ready_reg <= 1'b1;
        reset_done_reg <= 1'b0;
      end else if (not_ready_reg) begin
        if (init_cnt_reg == `INIT_CYC - 12'h001) begin
          not_ready_reg <= 1'b0;
          reset_done_reg <= 1'b1;
        end else begin
          init_cnt_reg <= init_cnt_reg + 12'h001;
        end
      end else if (status_read) begin
        reset_done_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Monitor threshold compare
  // ----------------------------------------
  wire [223:0] mon_all;
  wire [55:0] mon_flag;

  assign mon_all = {tx_power_monitor, tx_bias_monitor, rx_power_monitor, vcc_monitor,
                    temp_monitor};

  function [63:0] threshold;
    input integer idx;
    begin
      if (idx == 0) begin
        threshold = `TH_TEMP;
      end else if (idx == 1) begin
        threshold = `TH_VCC;
      end else if (idx < 6) begin
        threshold = `TH_RX_POWER;
      end else if (idx < 10) begin
        threshold = `TH_TX_BIAS;
      end else begin
        threshold = `TH_TX_POWER;
      end
    end
  endfunction

  genvar gm;
  generate
    for (gm = 0; gm < 14; gm = gm + 1) begin : g_mon
      wire [15:0] value;
      wire [63:0] th;
      assign value = mon_all[16 * gm +: 16];
      assign th = threshold(gm);
      assign mon_flag[4 * gm +: 4] = {value > th[63:48], value < th[47:32],
                                      value > th[31:16], value < th[15:0]};
    end
  endgenerate

  // ----------------------------------------
  // Latched flags
  // ----------------------------------------
  wire [79:0] live_flag;
  reg [79:0] latched_reg;
  wire flag_any;

  assign live_flag = {mon_flag, tx_lock_loss_flag, rx_lock_loss_flag, 4'h0, tx_fault,
                      tx_signal_loss_flag, rx_signal_loss_flag};
  assign flag_any = |latched_reg;

  genvar gf;
  generate
    for (gf = 0; gf < 10; gf = gf + 1) begin : g_flag
      wire clear_rd;
      assign clear_rd = rd_strobe && (reg_addr == `OFS_FLAG_BASE + gf);
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          latched_reg[8 * gf +: 8] <= 8'h00;
        end else if (reset_hold_reg) begin
          latched_reg[8 * gf +: 8] <= 8'h00;
        end else if (clear_rd) begin
          latched_reg[8 * gf +: 8] <= live_flag[8 * gf +: 8];
        end else begin
          latched_reg[8 * gf +: 8] <= live_flag[8 * gf +: 8] | latched_reg[8 * gf +: 8];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Host settings
  // ----------------------------------------
  reg [7:0] set_reg [0:5];
  reg power_override_reg;
  reg power_set_reg;

  genvar gs;
  generate
    for (gs = 0; gs < 6; gs = gs + 1) begin : g_set
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          set_reg[gs] <= `SETTING_RESET;
        end else if (reset_hold_reg) begin
          set_reg[gs] <= `SETTING_RESET;
        end else if (wr_strobe && reg_addr == `OFS_SET_BASE + gs) begin
          set_reg[gs] <= wr_data;
        end
      end
    end
  endgenerate

  assign tx_equalization = {set_reg[1], set_reg[0]};
  assign rx_output_amplitude = {set_reg[3], set_reg[2]};
  assign rx_output_emphasis = {set_reg[5], set_reg[4]};

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_override_reg <= 1'b0;
      power_set_reg <= 1'b0;
    end else if (reset_hold_reg) begin
      power_override_reg <= 1'b0;
      power_set_reg <= 1'b0;
    end else if (wr_strobe && reg_addr == `OFS_POWER) begin
      power_override_reg <= wr_data[`BIT_PWR_OVERRIDE];
      power_set_reg <= wr_data[`BIT_PWR_SET];
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  wire int_active;

  assign int_active = reset_done_reg || flag_any;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      module_present_n <= 1'b0;
      sda_out <= 1'b0;
      interrupt_n_out <= 1'b0;
      interrupt_n_oe_n <= 1'b1;
      high_power_enable <= 1'b0;
    end else begin
      module_present_n <= 1'b0;
      sda_out <= 1'b0;
      interrupt_n_out <= 1'b0;
      interrupt_n_oe_n <= !int_active;
      high_power_enable <= !not_ready_reg && !reset_hold_reg &&
                           (!low_power_s || (power_override_reg && power_set_reg));
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg [7:0] flag_idx;
  reg [7:0] mon_idx;
  reg [7:0] set_idx;
  reg [15:0] mon_word;

  always @* begin
    flag_idx = reg_addr - `OFS_FLAG_BASE;
    mon_idx = reg_addr - `OFS_MON_BASE;
    set_idx = reg_addr - `OFS_SET_BASE;
    mon_word = 16'h0000;
    rd_data = 8'h00;
    if (reg_addr == `OFS_STATUS) begin
      rd_data = {6'h00, int_active, not_ready_reg};
    end else if (reg_addr >= `OFS_FLAG_BASE && flag_idx < `FLAG_BYTES) begin
      rd_data = latched_reg[{flag_idx[3:0], 3'b000} +: 8];
    end else if (reg_addr >= `OFS_MON_BASE && mon_idx < `MON_BYTES) begin
      mon_word = mon_all[{mon_idx[4:1], 4'h0} +: 16];
      rd_data = mon_idx[0] ? mon_word[7:0] : mon_word[15:8];
    end else if (reg_addr == `OFS_POWER) begin
      rd_data = {6'h00, power_set_reg, power_override_reg};
    end else if (reg_addr >= `OFS_SET_BASE && set_idx < `SET_BYTES) begin
      rd_data = set_reg[set_idx[2:0]];
    end
  end
endmodule

// ==== logic/sideband_defines.vh ====
`ifndef SIDEBAND_DEFINES_VH
`define SIDEBAND_DEFINES_VH

// ----------------------------------------
// Serial bus address and map
// ----------------------------------------
`define DEV_ADDR 7'h50
`define OFS_STATUS 8'h02
`define STATUS_READY_BIT 0
`define STATUS_INT_BIT 1
`define OFS_FLAG_BASE 8'h03
`define FLAG_BYTES 8'h0a
`define OFS_MON_BASE 8'h16
`define MON_BYTES 8'h1c
`define OFS_POWER 8'h5d
`define BIT_PWR_OVERRIDE 0
`define BIT_PWR_SET 1
`define OFS_SET_BASE 8'h60
`define SET_BYTES 8'h06
`define SETTING_RESET 8'h00

// ----------------------------------------
// Fixed thresholds {high alarm, low alarm, high warn, low warn}
// ----------------------------------------
`define TH_TEMP 64'h4b00_0100_4600_0300
`define TH_VCC 64'h8c3c_7148_8840_7530
`define TH_RX_POWER 64'h6000_0100_5000_0200
`define TH_TX_BIAS 64'h9000_0800_8000_1000
`define TH_TX_POWER 64'h6000_0200_5000_0400

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define RESET_MIN_NS 10000
`define RESET_MIN_CYC 12'd2000
`define INIT_TIME_NS 2000
`define INIT_CYC 12'd400
`endif

// ==== logic/twi_target.v ====
`timescale 1ns/1ps
`include "sideband_defines.vh"
module twi_target (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Synchronised bus levels
  input wire scl_level,
  input wire sda_level,
  input wire enable,
  output wire sda_oe_n,
  // Register access
  output wire [7:0] reg_addr,
  output wire wr_strobe,
  output wire [7:0] wr_data,
  output wire rd_strobe,
  input wire [7:0] rd_data
);
  localparam ST_IDLE = 4'h0;
  localparam ST_ADDR = 4'h1;
  localparam ST_ADDR_ACK = 4'h2;
  localparam ST_PTR = 4'h3;
  localparam ST_PTR_ACK = 4'h4;
  localparam ST_WR = 4'h5;
  localparam ST_WR_ACK = 4'h6;
  localparam ST_RD = 4'h7;
  localparam ST_RD_ACK = 4'h8;

  reg [3:0] state_reg;
  reg [3:0] bcnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg rw_reg;
  reg ack_reg;
  reg scl_prev_reg;
  reg sda_prev_reg;
  reg sda_oe_n_reg;
  reg wr_strobe_reg;
  reg rd_strobe_reg;

  assign sda_oe_n = sda_oe_n_reg;
  assign reg_addr = ptr_reg;
  assign wr_strobe = wr_strobe_reg;
  assign wr_data = shift_reg;
  assign rd_strobe = rd_strobe_reg;

  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      bcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      ack_reg <= 1'b0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      wr_strobe_reg <= 1'b0;
      rd_strobe_reg <= 1'b0;
    end else begin
      scl_prev_reg <= scl_level;
      sda_prev_reg <= sda_level;
      wr_strobe_reg <= 1'b0;
      rd_strobe_reg <= 1'b0;
      if (!enable) begin
        state_reg <= ST_IDLE;
        sda_oe_n_reg <= 1'b1;
      end else if (scl_level && scl_prev_reg && sda_prev_reg && !sda_level) begin
        state_reg <= ST_ADDR;
        bcnt_reg <= 4'h0;
        sda_oe_n_reg <= 1'b1;
      end else if (scl_level && scl_prev_reg && !sda_prev_reg && sda_level) begin
        state_reg <= ST_IDLE;
        sda_oe_n_reg <= 1'b1;
      end else if (scl_level && !scl_prev_reg) begin
        case (state_reg)
          ST_ADDR, ST_PTR, ST_WR: begin
            shift_reg <= {shift_reg[6:0], sda_level};
            bcnt_reg <= bcnt_reg + 4'h1;
          end
          ST_RD: begin
            bcnt_reg <= bcnt_reg + 4'h1;
          end
          ST_RD_ACK: begin
            ack_reg <= !sda_level;
          end
          default: begin
            bcnt_reg <= bcnt_reg;
          end
        endcase
      end else if (!scl_level && scl_prev_reg) begin
        case (state_reg)
          ST_ADDR: begin
            if (bcnt_reg == 4'h8) begin
              if (shift_reg[7:1] == `DEV_ADDR) begin
                rw_reg <= shift_reg[0];
                sda_oe_n_reg <= 1'b0;
                state_reg <= ST_ADDR_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK, ST_RD_ACK: begin
            bcnt_reg <= 4'h0;
            if ((state_reg == ST_ADDR_ACK && rw_reg) || (state_reg == ST_RD_ACK && ack_reg)) begin
              shift_reg <= rd_data;
              sda_oe_n_reg <= rd_data[7];
              rd_strobe_reg <= 1'b1;
              state_reg <= ST_RD;
            end else if (state_reg == ST_ADDR_ACK) begin
              sda_oe_n_reg <= 1'b1;
              state_reg <= ST_PTR;
            end else begin
              sda_oe_n_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
          ST_PTR: begin
            if (bcnt_reg == 4'h8) begin
              ptr_reg <= shift_reg;
              sda_oe_n_reg <= 1'b0;
              state_reg <= ST_PTR_ACK;
            end
          end
          ST_PTR_ACK, ST_WR_ACK: begin
            bcnt_reg <= 4'h0;
            sda_oe_n_reg <= 1'b1;
            state_reg <= ST_WR;
          end
          ST_WR: begin
            if (bcnt_reg == 4'h8) begin
              wr_strobe_reg <= 1'b1;
              sda_oe_n_reg <= 1'b0;
              state_reg <= ST_WR_ACK;
            end
          end
          ST_RD: begin
            if (bcnt_reg == 4'h8) begin
              sda_oe_n_reg <= 1'b1;
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_RD_ACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_n_reg <= shift_reg[6];
            end
          end
          default: begin
            sda_oe_n_reg <= 1'b1;
          end
        endcase
      end
      if (wr_strobe_reg) begin
        ptr_reg <= ptr_reg + 8'h01;
      end
    end
  end
endmodule

// ==== tb/host_twi.sv ====
`timescale 1ns/1ps
`include "sideband_defines.vh"
// ----------------------------------------
// Host controller on the two-wire bus.
// ----------------------------------------
module host_twi (
  // Bus lines
  input wire sda_wire,
  output reg scl,
  output reg sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task bit_cycle(input logic b, output logic s);
    begin
      sda_low = !b;
      #12 scl = 1'b1;
      #12 s = sda_wire;
      #12 scl = 1'b0;
      #12;
    end
  endtask
  task send_byte(input logic [7:0] d, output logic ack);
    integer i;
    logic s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_cycle(d[i], s);
      end
      bit_cycle(1'b1, s);
      ack = !s;
    end
  endtask
  task start_cond;
    begin
      sda_low = 1'b1;
      #24 scl = 1'b0;
      #12;
    end
  endtask
  task stop_cond;
    begin
      sda_low = 1'b1;
      #12 scl = 1'b1;
      #24 sda_low = 1'b0;
      #24;
    end
  endtask
  task write_reg(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    logic a1;
    logic a2;
    logic a3;
    begin
      start_cond;
      send_byte({`DEV_ADDR, 1'b0}, a1);
      send_byte(ofs, a2);
      send_byte(d, a3);
      stop_cond;
      ok = a1 & a2 & a3;
    end
  endtask
  task read_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    integer i;
    logic a1;
    logic a2;
    logic a3;
    logic s;
    begin
      start_cond;
      send_byte({`DEV_ADDR, 1'b0}, a1);
      send_byte(ofs, a2);
      sda_low = 1'b0;
      #12 scl = 1'b1;
      #24 sda_low = 1'b1;
      #24 scl = 1'b0;
      #12;
      send_byte({`DEV_ADDR, 1'b1}, a3);
      for (i = 7; i >= 0; i = i - 1) begin
        bit_cycle(1'b1, d[i]);
      end
      bit_cycle(1'b1, s);
      stop_cond;
      ok = a1 & a2 & a3;
    end
  endtask
endmodule

// ==== tb/module_sideband_management_test.sv ====
`timescale 1ns/1ps
`include "sideband_defines.vh"
// ----------------------------------------
// Bench for the sideband block.
// ----------------------------------------
module module_sideband_management_test;
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg module_select_n = 1'b1;
  reg module_reset_n = 1'b1;
  reg low_power_request = 1'b1;
  reg [19:0] flag_bus = 20'h00000;
  reg [15:0] temp_monitor = 16'h2000;
  reg [15:0] vcc_monitor = 16'h8000;
  reg [63:0] rx_power_monitor = {4{16'h3000}};
  reg [63:0] tx_bias_monitor = {4{16'h4000}};
  reg [63:0] tx_power_monitor = {4{16'h3000}};
  wire scl, sda_low, sda_out, sda_oe_n, interrupt_n_out, interrupt_n_oe_n, module_present_n;
  wire high_power_enable;
  wire [15:0] tx_equalization, rx_output_amplitude, rx_output_emphasis;
  wire sda_wire = !(sda_low || !sda_oe_n);
  integer n_fail = 0;
  integer checked = 0;
  logic [15:0] v;
  always #2.5 ref_clk = !ref_clk;
  module_sideband i_module_sideband (.ref_clk, .rst_b, .module_select_n, .module_reset_n,
    .low_power_request, .scl, .sda_in(sda_wire), .sda_out, .sda_oe_n, .interrupt_n_out,
    .interrupt_n_oe_n, .module_present_n, .tx_signal_loss_flag(flag_bus[19:16]),
    .rx_signal_loss_flag(flag_bus[15:12]), .tx_lock_loss_flag(flag_bus[11:8]),
    .rx_lock_loss_flag(flag_bus[7:4]), .tx_fault(flag_bus[3:0]), .temp_monitor, .vcc_monitor,
    .rx_power_monitor, .tx_bias_monitor, .tx_power_monitor, .high_power_enable,
    .tx_equalization, .rx_output_amplitude, .rx_output_emphasis);
  host_twi i_host_twi (.sda_wire, .scl, .sda_low);
  task tally_and_finish;
    begin
      $display("Checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: %s", $time, msg);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1.2;
    end
  endtask
  task wait_int;
    integer n;
    begin
      n = 0;
      while (interrupt_n_oe_n !== 1'b0 && n < 600) begin
        tick(1);
        n = n + 1;
      end
    end
  endtask
  task rd(input logic [7:0] ofs, output logic [15:0] r);
    logic [7:0] b;
    logic ok;
    begin
      i_host_twi.read_reg(ofs, b, ok);
      check({15'h0000, ok}, 16'h0001, "read not answered");
      r = {8'h00, b};
    end
  endtask
  task wr(input logic [7:0] ofs, input logic [7:0] d);
    logic ok;
    begin
      i_host_twi.write_reg(ofs, d, ok);
      check({15'h0000, ok}, 16'h0001, "write not answered");
    end
  endtask
  task t_startup;
    begin
      check({15'h0000, module_present_n}, 16'h0000, "presence");
      check({15'h0000, high_power_enable}, 16'h0000, "power at start");
      wait_int;
      check({15'h0000, interrupt_n_oe_n}, 16'h0000, "no reset done interrupt");
      rd(`OFS_STATUS, v);
      check(v, 16'h0002, "status after init");
      check({15'h0000, interrupt_n_oe_n}, 16'h0001, "interrupt not released");
    end
  endtask
  task t_select;
    logic ok;
    begin
      module_select_n = 1'b1;
      tick(4);
      i_host_twi.write_reg(8'h60, 8'h5a, ok);
      check({15'h0000, ok}, 16'h0000, "answer while deselected");
      module_select_n = 1'b0;
      tick(4);
      i_host_twi.start_cond;
      i_host_twi.send_byte(8'ha4, ok);
      i_host_twi.stop_cond;
      check({15'h0000, ok}, 16'h0000, "answer to other address");
      rd(8'h60, v);
      check(v, 16'h0000, "setting written while deselected");
    end
  endtask
  task t_settings;
    logic [7:0] k;
    begin
      for (k = 8'h00; k < 8'h06; k = k + 8'h01) begin
        wr(`OFS_SET_BASE + k, (k + 8'h01) * 8'h11);
      end
      check(tx_equalization, 16'h2211, "tx equalization");
      check(rx_output_amplitude, 16'h4433, "rx amplitude");
      check(rx_output_emphasis, 16'h6655, "rx emphasis");
    end
  endtask
  task t_power;
    begin
      rd(`OFS_POWER, v);
      check(v, 16'h0000, "power bits default");
      low_power_request = 1'b0;
      tick(5);
      check({15'h0000, high_power_enable}, 16'h0001, "pin high power");
      low_power_request = 1'b1;
      tick(5);
      check({15'h0000, high_power_enable}, 16'h0000, "pin low power");
      wr(`OFS_POWER, 8'h01);
      check({15'h0000, high_power_enable}, 16'h0000, "override alone");
      wr(`OFS_POWER, 8'h03);
      check({15'h0000, high_power_enable}, 16'h0001, "override and set");
      rd(`OFS_POWER, v);
      check(v, 16'h0003, "power bits readback");
    end
  endtask
  task t_flags;
    logic [7:0] k;
    logic [7:0] ofs;
    begin
      for (k = 8'h00; k < 8'h05; k = k + 8'h01) begin
        ofs = (k < 8'h02) ? 8'h03 : ((k < 8'h04) ? 8'h05 : 8'h04);
        flag_bus = 20'h20000 >> {k, 2'b00};
        tick(4);
        check({15'h0000, interrupt_n_oe_n}, 16'h0000, "flag interrupt");
        flag_bus = 20'h00000;
        rd(ofs, v);
        check(v, (k[0] || k == 8'h04) ? 16'h0002 : 16'h0020, "flag byte");
        check({15'h0000, interrupt_n_oe_n}, 16'h0001, "flag not cleared");
      end
    end
  endtask
  task t_monitor;
    integer j;
    begin
      rd(8'h16, v);
      check(v, 16'h0020, "temperature high byte");
      rd(8'h1a, v);
      check(v, 16'h0030, "rx power lane high byte");
      for (j = 0; j < 2; j = j + 1) begin
        temp_monitor = j ? 16'h4c00 : 16'h4800;
        tick(4);
        check({15'h0000, interrupt_n_oe_n}, 16'h0000, "threshold interrupt");
        temp_monitor = 16'h2000;
        rd(8'h06, v);
        check(v, j ? 16'h000a : 16'h0002, "threshold flags");
      end
    end
  endtask
  task t_resets;
    begin
      module_reset_n = 1'b0;
      tick(1000);
      module_reset_n = 1'b1;
      tick(10);
      check(tx_equalization, 16'h2211, "short pulse setting");
      check({15'h0000, high_power_enable}, 16'h0001, "short pulse power");
      module_reset_n = 1'b0;
      tick(2100);
      check(rx_output_amplitude, 16'h0000, "long reset setting");
      check({15'h0000, high_power_enable}, 16'h0000, "long reset power");
      module_reset_n = 1'b1;
      wait_int;
      check({15'h0000, interrupt_n_oe_n}, 16'h0000, "reset done after hold");
      rd(`OFS_POWER, v);
      check(v, 16'h0000, "power bits after reset");
      rd(`OFS_STATUS, v);
      check(v, 16'h0002, "status after reset");
    end
  endtask
  initial begin
    #200000;
    n_fail = n_fail + 1;
    tally_and_finish;
  end
  initial begin
    tick(20);
    rst_b = 1'b1;
    module_select_n = 1'b0;
    tick(3);
    t_startup;
    t_select;
    t_settings;
    t_power;
    t_flags;
    t_monitor;
    t_resets;
    tally_and_finish;
  end
endmodule

// ==== tb/sideband_monitor.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the sideband block.
// ----------------------------------------
module sideband_monitor (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Host pins
  input wire module_select_n,
  input wire module_reset_n,
  input wire sda_out,
  input wire sda_oe_n,
  input wire interrupt_n_out,
  input wire interrupt_n_oe_n,
  input wire module_present_n,
  // Status flags
  input wire [3:0] tx_signal_loss_flag,
  input wire [3:0] rx_signal_loss_flag,
  input wire [3:0] tx_lock_loss_flag,
  input wire [3:0] rx_lock_loss_flag,
  input wire [3:0] tx_fault,
  // Lane controls
  input wire high_power_enable,
  input wire [15:0] tx_equalization,
  input wire [15:0] rx_output_amplitude,
  input wire [15:0] rx_output_emphasis
);
  reg [9:0] up_cnt_reg;
  reg [11:0] hold_cnt_reg;
  wire flag_any;
  assign flag_any = |{tx_signal_loss_flag, rx_signal_loss_flag, tx_lock_loss_flag,
                      rx_lock_loss_flag, tx_fault};
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt_reg <= 10'h000;
      hold_cnt_reg <= 12'h000;
    end else begin
      if (up_cnt_reg != 10'h3ff) begin
        up_cnt_reg <= up_cnt_reg + 10'h001;
      end
      if (module_reset_n) begin
        hold_cnt_reg <= 12'h000;
      end else if (hold_cnt_reg != 12'hfff) begin
        hold_cnt_reg <= hold_cnt_reg + 12'h001;
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_present_low;
    module_present_n == 1'b0;
  endproperty
  a_present_low: assert property (p_present_low)
    else $error("presence output not low");
  property p_deselect_quiet;
    module_select_n [*6] |-> sda_oe_n;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet)
    else $error("data line pulled while deselected");
  property p_open_drain;
    interrupt_n_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain level not low");
  property p_init_quiet;
    up_cnt_reg < 10'h186 |-> interrupt_n_oe_n && !high_power_enable;
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("early interrupt or high power");
  property p_init_done;
    up_cnt_reg == 10'h1a4 |-> !interrupt_n_oe_n;
  endproperty
  a_init_done: assert property (p_init_done)
    else $error("reset done interrupt missing");
  property p_flag_int;
    flag_any && module_reset_n |-> ##[1:4] !interrupt_n_oe_n;
  endproperty
  a_flag_int: assert property (p_flag_int)
    else $error("flag not on interrupt");
  property p_hold_power;
    hold_cnt_reg > 12'h7e4 |-> !high_power_enable;
  endproperty
  a_hold_power: assert property (p_hold_power)
    else $error("high power during reset hold");
  property p_hold_settings;
    hold_cnt_reg > 12'h7e4 |->
      (tx_equalization | rx_output_amplitude | rx_output_emphasis) == 16'h0000;
  endproperty
  a_hold_settings: assert property (p_hold_settings)
    else $error("settings kept during reset hold");
  property p_short_keep;
    !module_reset_n && hold_cnt_reg < 12'h7c0 |=>
      $stable(tx_equalization) && $stable(high_power_enable);
  endproperty
  a_short_keep: assert property (p_short_keep)
    else $error("short reset pulse changed state");
  c_high_power: cover property (high_power_enable);
  c_int_release: cover property (!interrupt_n_oe_n ##1 interrupt_n_oe_n);
  c_long_hold: cover property (hold_cnt_reg == 12'h7e5);
endmodule
bind module_sideband sideband_monitor i_sideband_monitor (.ref_clk, .rst_b, .module_select_n,
  .module_reset_n, .sda_out, .sda_oe_n, .interrupt_n_out, .interrupt_n_oe_n, .module_present_n,
  .tx_signal_loss_flag, .rx_signal_loss_flag, .tx_lock_loss_flag, .rx_lock_loss_flag, .tx_fault,
  .high_power_enable, .tx_equalization, .rx_output_amplitude, .rx_output_emphasis);
